// ==== hw/flash_command_host.sv ====
// Flash host controller: AXI4-Lite registers and command sequences on the flash pins
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`include "flash_host_consts.svh"
// Notes on behaviour
// - Never drive data while output enable low
// - Identifier reads use lowest bit, others zero
// - Code FFH returns device to array reads
// - Program is 40H or 10H, then address/data
// - Erase 20H+D0H, suspend B0H, resume D0H
// - Code 71H then read extended status
// - Buffer read 75H, single buffer load 74H
// - Sequential load E0H, low and high counts
// - Counts are minus one, high count zero
// - Buffer write 0CH, counts, then address
// - Two-byte program FBH takes two bytes
// - Upload 97H+D0H, lock 77H+D0H
// - Check ready bit before error bits
module flash_command_host
	import flash_host_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output flash_pins_t      pins,
	input  wire logic [15:0] data_in,
	input  wire logic        ready_busy_n
);

// ****************************************
// Declarations
// ****************************************
logic [3:0]  control;       // Power, width, supply, alternate code
logic [20:0] user_addr;     // Address for the next operation
logic [31:0] user_data;     // Data and second data
logic [4:0]  op_q;          // Operation under way or last run
logic        done;          // Last operation finished
logic        aw_take;       // Write address and data accepted
logic        ar_take;       // Read address accepted
bus_state_t  state;         // Pin sequencer state
logic [1:0]  idx;           // Step of the sequence
logic [2:0]  cnt;           // Strobe width counter
step_t       cur;           // Step on the pins
step_t       next_step;     // Step about to start
logic        rd_slot;       // Which read half is next
logic [15:0] read_lo;       // First read result
logic [15:0] read_hi;       // Second read result
logic [7:0]  legacy_status; // Copy of the device compatible status
logic        status_seen;   // A status read has happened
logic [20:0] addr_q;        // Address pins
logic [15:0] dout_q;        // Data pins
logic        doe_q;         // Data pins driven
logic        ce_n_q;        // Both chip selects
logic        oe_n_q;        // Output enable pin
logic        we_n_q;        // Write strobe pin
logic        wr_fire;       // Write transfer this cycle
logic [3:0]  wr_dec;        // Decoded write address
logic [3:0]  rd_dec;        // Decoded read address
logic        cmd_start;     // Accepted command
logic        busy;          // Sequencer not idle
logic        strobe_end;    // Last strobe cycle
logic [31:0] status_word;   // Status register value
logic [31:0] rd_word;       // Read mux output

// ****************************************
// Functions
// ****************************************
// Hit flag and word index of a register address
function automatic logic [3:0] decode(input logic [7:0] a);
	decode = {(a[1:0] == 2'h0) && (a[7:5] == 3'h0) && (a[4:2] <= `FC_IDX_READ), a[4:2]};
endfunction : decode

// Byte-lane merge of a write
function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	input logic [3:0] strb);
	merge = old;
	for (int b = 0; b < 4; b++) begin
		if (strb[b]) begin
			merge[8*b +: 8] = nw[8*b +: 8];
		end
	end
endfunction : merge

// Step builders
function automatic step_t mk(input cyc_kind_t k, input addr_src_t a, input data_src_t d,
	input logic [7:0] c);
	mk = '{kind: k, asrc: a, dsrc: d, code: c};
endfunction : mk

function automatic step_t cmd(input logic [7:0] c);
	cmd = mk(CK_WRITE, AS_ZERO, DS_CODE, c);
endfunction : cmd

// Cycle list of each operation
function automatic step_t step_of(input logic [4:0] o, input logic [1:0] i, input logic alt);
	step_t s0;
	step_t s1;
	step_t s2;
	s0 = mk(CK_END, AS_ZERO, DS_CODE, 8'h00);
	s1 = s0;
	s2 = s0;
	case (o)
	`FC_OP_WRITE: s0 = mk(CK_WRITE, AS_USER, DS_DATA, 8'h00);
	`FC_OP_READ: s0 = mk(CK_READ, AS_USER, DS_CODE, 8'h00);
	`FC_OP_ARRAY: begin
		s0 = cmd(`FC_CMD_ARRAY);
		s1 = mk(CK_READ, AS_USER, DS_CODE, 8'h00);
	end
	`FC_OP_IDENT: begin
		s0 = cmd(`FC_CMD_IDENT);
		s1 = mk(CK_READ, AS_ZERO, DS_CODE, 8'h00);
		s2 = mk(CK_READ, AS_LOWBIT, DS_CODE, 8'h00);
	end
	`FC_OP_STATUS: begin
		s0 = cmd(`FC_CMD_STATUS);
		s1 = mk(CK_READ, AS_ZERO, DS_CODE, 8'h00);
	end
	`FC_OP_CLEAR: s0 = cmd(`FC_CMD_CLEAR);
	`FC_OP_PROGRAM: begin
		s0 = cmd(alt ? `FC_CMD_PROG_ALT : `FC_CMD_PROGRAM);
		s1 = mk(CK_WRITE, AS_USER, DS_DATA, 8'h00);
	end
	`FC_OP_ERASE: begin
		s0 = cmd(`FC_CMD_ERASE);
		s1 = mk(CK_WRITE, AS_USER, DS_CODE, `FC_CMD_CONFIRM);
	end
	`FC_OP_SUSPEND: s0 = cmd(`FC_CMD_SUSPEND);
	`FC_OP_RESUME: s0 = cmd(`FC_CMD_CONFIRM);
	`FC_OP_EXT_STATUS: begin
		s0 = cmd(`FC_CMD_EXT_STAT);
		s1 = mk(CK_READ, AS_USER, DS_CODE, 8'h00);
	end
	`FC_OP_BUF_READ: begin
		s0 = cmd(`FC_CMD_BUF_READ);
		s1 = mk(CK_READ, AS_USER, DS_CODE, 8'h00);
	end
	`FC_OP_BUF_LOAD: begin
		s0 = cmd(`FC_CMD_BUF_LOAD);
		s1 = mk(CK_WRITE, AS_USER, DS_DATA, 8'h00);
	end
	`FC_OP_SEQ_LOAD: begin
		s0 = cmd(`FC_CMD_SEQ_LOAD);
		s1 = mk(CK_WRITE, AS_ZERO, DS_DATA, 8'h00);
		s2 = cmd(`FC_COUNT_HIGH);
	end
	`FC_OP_BUF_FLASH: begin
		s0 = cmd(`FC_CMD_BUF_FLASH);
		s1 = mk(CK_WRITE, AS_ZERO, DS_DATA, 8'h00);
		s2 = mk(CK_WRITE, AS_USER, DS_CODE, `FC_COUNT_HIGH);
	end
	`FC_OP_TWO_BYTE: begin
		s0 = cmd(`FC_CMD_TWO_BYTE);
		s1 = mk(CK_WRITE, AS_USER, DS_DATA, 8'h00);
		s2 = mk(CK_WRITE, AS_USER, DS_DATA2, 8'h00);
	end
	`FC_OP_LOCK: begin
		s0 = cmd(`FC_CMD_LOCK);
		s1 = mk(CK_WRITE, AS_USER, DS_CODE, `FC_CMD_CONFIRM);
	end
	`FC_OP_UPLOAD: begin
		s0 = cmd(`FC_CMD_UPLOAD);
		s1 = cmd(`FC_CMD_CONFIRM);
	end
	`FC_OP_ERASE_ALL: begin
		s0 = cmd(`FC_CMD_ERASE_ALL);
		s1 = cmd(`FC_CMD_CONFIRM);
	end
	`FC_OP_RB_CONFIG: begin
		s0 = cmd(`FC_CMD_RB_CONFIG);
		s1 = mk(CK_WRITE, AS_ZERO, DS_DATA, 8'h00);
	end
	`FC_OP_SWAP: s0 = cmd(`FC_CMD_SWAP);
	`FC_OP_ABORT: s0 = cmd(`FC_CMD_ABORT);
	`FC_OP_SLEEP: s0 = cmd(`FC_CMD_SLEEP);
	default: ;
	endcase
	step_of = (i == 2'h0) ? s0 : ((i == 2'h1) ? s1 : s2);
endfunction : step_of

// ****************************************
// Register bus
// ****************************************
assign wr_fire = aw_take && awvalid && wvalid;
assign wr_dec = decode(awaddr);
assign rd_dec = decode(araddr);
assign busy = (state != BS_IDLE);
assign cmd_start = wr_fire && wr_dec[3] && (wr_dec[2:0] == `FC_IDX_COMMAND) && !busy;
assign awready = aw_take;
assign wready = aw_take;
assign arready = ar_take;

// Write channel handshake and register stores
always_ff @(posedge clock or negedge reset_n) begin
	if (!reset_n) begin
		aw_take <= 1'b0;
		bvalid <= 1'b0;
		bresp <= `FC_RESP_OKAY;
		control <= `FC_CTL_RESET;
		user_addr <= 21'h000000;
		user_data <= 32'h00000000;
		op_q <= 5'h00;
	end else begin
		aw_take <= awvalid && wvalid && !aw_take && !bvalid;
		if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
		if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= `FC_RESP_OKAY;
			if (!wr_dec[3]) begin // Unmapped
				bresp <= `FC_RESP_SLVERR;
			end else begin
				case (wr_dec[2:0])
				`FC_IDX_CONTROL: if (wstrb[0]) begin
					control <= wdata[3:0];
				end
				`FC_IDX_ADDRESS: user_addr <= 21'(merge({11'h000, user_addr}, wdata, wstrb));
				`FC_IDX_DATA: user_data <= merge(user_data, wdata, wstrb);
				`FC_IDX_COMMAND: if (busy) begin // Refused while a sequence runs
					bresp <= `FC_RESP_SLVERR;
				end else begin
					op_q <= wdata[4:0];
				end
				default: ; // Read-only words ignore writes
				endcase
			end
		end
	end
end

// Status word: pin, flags and decoded copy of device status
always_comb begin
	status_word = 32'h00000000;
	status_word[0] = busy;
	status_word[1] = done;
	status_word[2] = ready_busy_n;
	status_word[3] = status_seen && legacy_status[7];
	status_word[4] = status_word[3] && legacy_status[5];
	status_word[5] = status_word[3] && legacy_status[4];
	status_word[6] = status_word[3] && legacy_status[3];
	status_word[7] = status_word[4] && status_word[5];
	status_word[15:8] = legacy_status;
	status_word[28:24] = user_addr[20:16];
end

// Read mux
always_comb begin
	case (rd_dec[2:0])
	`FC_IDX_CONTROL: rd_word = {28'h0000000, control};
	`FC_IDX_ADDRESS: rd_word = {11'h000, user_addr};
	`FC_IDX_DATA: rd_word = user_data;
	`FC_IDX_COMMAND: rd_word = {27'h0000000, op_q};
	`FC_IDX_STATUS: rd_word = status_word;
	default: rd_word = {read_hi, read_lo};
	endcase
end

// Read channel handshake
always_ff @(posedge clock or negedge reset_n) begin
	if (!reset_n) begin
		ar_take <= 1'b0;
		rvalid <= 1'b0;
		rdata <= 32'h00000000;
		rresp <= `FC_RESP_OKAY;
	end else begin
		ar_take <= arvalid && !ar_take && !rvalid;
		if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
		if (ar_take && arvalid) begin
			rvalid <= 1'b1;
			rdata <= rd_dec[3] ? rd_word : 32'h00000000;
			rresp <= rd_dec[3] ? `FC_RESP_OKAY : `FC_RESP_SLVERR;
		end
	end
end

// ****************************************
// Pin sequencer
// ****************************************
assign next_step = step_of(op_q, idx, control[`FC_CTL_ALT]);
assign strobe_end = (state == BS_STROBE) && (cnt == 3'(`FC_STROBE_CYC - 1));

// Walks the steps, one bus cycle each
always_ff @(posedge clock or negedge reset_n) begin
	if (!reset_n) begin
		state <= BS_IDLE;
		idx <= 2'h0;
		cnt <= 3'h0;
		cur <= '0;
		done <= 1'b0;
		addr_q <= 21'h000000;
		dout_q <= 16'h0000;
		doe_q <= 1'b0;
		ce_n_q <= 1'b1;
		oe_n_q <= 1'b1;
		we_n_q <= 1'b1;
	end else begin
		case (state)
		BS_IDLE: if (cmd_start) begin
			idx <= 2'h0;
			done <= 1'b0;
			state <= BS_FETCH;
		end
		BS_FETCH: begin
			cur <= next_step;
			if (next_step.kind == CK_END) begin
				done <= 1'b1;
				state <= BS_IDLE;
			end else begin
				case (next_step.asrc)
				AS_USER: addr_q <= user_addr;
				AS_LOWBIT: addr_q <= control[`FC_CTL_WORD] ? 21'h000002 : 21'h000001;
				default: addr_q <= 21'h000000;
				endcase
				case (next_step.dsrc)
				DS_DATA: dout_q <= user_data[15:0];
				DS_DATA2: dout_q <= user_data[31:16];
				default: dout_q <= {8'h00, next_step.code};
				endcase
				doe_q <= (next_step.kind == CK_WRITE);
				ce_n_q <= 1'b0;
				state <= BS_SETUP;
			end
		end
		BS_SETUP: begin // Strobe only after address and data settle
			cnt <= 3'h0;
			we_n_q <= (cur.kind != CK_WRITE);
			oe_n_q <= (cur.kind != CK_READ);
			state <= BS_STROBE;
		end
		BS_STROBE: if (strobe_end) begin
			we_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			state <= BS_HOLD;
		end else begin
			cnt <= cnt + 3'h1;
		end
		BS_HOLD: begin // Data held past the rising strobe
			ce_n_q <= 1'b1;
			doe_q <= 1'b0;
			state <= BS_RECOVER;
		end
		BS_RECOVER: begin
			idx <= idx + 2'h1;
			if (idx == 2'h2) begin
				done <= 1'b1;
				state <= BS_IDLE;
			end else begin
				state <= BS_FETCH;
			end
		end
		default: state <= BS_IDLE;
		endcase
	end
end

// Captures read results and the status copy
always_ff @(posedge clock or negedge reset_n) begin
	if (!reset_n) begin
		rd_slot <= 1'b0;
		read_lo <= 16'h0000;
		read_hi <= 16'h0000;
		legacy_status <= 8'h00;
		status_seen <= 1'b0;
	end else begin
		if (cmd_start) begin
			rd_slot <= 1'b0;
		end else if (strobe_end && (cur.kind == CK_READ)) begin
			rd_slot <= 1'b1;
			if (rd_slot) begin
				read_hi <= data_in;
			end else begin
				read_lo <= data_in;
			end
		end
		if (!control[`FC_CTL_POWER]) begin
			legacy_status <= 8'h00;
			status_seen <= 1'b0;
		end else if (strobe_end && (cur.kind == CK_READ) && (op_q == `FC_OP_STATUS)) begin
			legacy_status <= data_in[7:0];
			status_seen <= 1'b1;
		end
	end
end

// Pin bundle straight from flip-flops
assign pins = '{address: addr_q, data_out: dout_q, data_oe: doe_q,
	chip_select_a_n: ce_n_q, chip_select_b_n: ce_n_q, output_enable_n: oe_n_q,
	write_strobe_n: we_n_q, power_down_reset_n: control[`FC_CTL_POWER],
	word_mode: control[`FC_CTL_WORD],
	program_supply_on: control[`FC_CTL_SUPPLY]};

// ****************************************
// Checks
// ****************************************
default clocking @(posedge clock); endclocking
default disable iff (!reset_n);

a_we_oe_apart: assert property (!(!we_n_q && !oe_n_q)) else $error("strobes overlap");
a_write_drives: assert property (!we_n_q |-> doe_q && !ce_n_q)
	else $error("write without data");
a_read_floats: assert property (!oe_n_q |-> !doe_q && !ce_n_q)
	else $error("read with data driven");
a_strobe_width: assert property ($fell(we_n_q) |-> !we_n_q [*3])
	else $error("write strobe too short");
a_data_hold: assert property ($rose(we_n_q) |-> doe_q && $stable(dout_q) && $stable(addr_q))
	else $error("data not held at strobe rise");
a_ident_addr: assert property ((op_q == `FC_OP_IDENT) && !oe_n_q |-> addr_q[20:2] == 19'h00000)
	else $error("identifier address not zero");
a_count_high: assert property (((op_q == `FC_OP_SEQ_LOAD) || (op_q == `FC_OP_BUF_FLASH))
	&& (idx == 2'h2) && !we_n_q |-> dout_q == 16'h0000) else $error("high count not zero");
a_program_code: assert property ((op_q == `FC_OP_PROGRAM) && (idx == 2'h0) && !we_n_q
	|-> (dout_q[7:0] == 8'h40) || (dout_q[7:0] == 8'h10)) else $error("bad program code");
a_erase_confirm: assert property ((op_q == `FC_OP_ERASE) && (idx == 2'h1) && !we_n_q
	|-> dout_q[7:0] == 8'hD0 && addr_q == user_addr) else $error("bad erase confirm");
a_seq_ends: assert property ((state == BS_RECOVER) && (idx == 2'h2) |=> state == BS_IDLE)
	else $error("sequence overran");

endmodule : flash_command_host

// ==== hw/flash_host_consts.svh ====
// Offsets, field positions, operation numbers, command codes and timing of the flash host
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH
// Register word indices (byte address = index * 4)
`define FC_IDX_CONTROL 3'h0
`define FC_IDX_ADDRESS 3'h1
`define FC_IDX_DATA    3'h2
`define FC_IDX_COMMAND 3'h3
`define FC_IDX_STATUS  3'h4
`define FC_IDX_READ    3'h5
// Control register bits and reset value
`define FC_CTL_POWER   0
`define FC_CTL_WORD    1
`define FC_CTL_SUPPLY  2
`define FC_CTL_ALT     3
`define FC_CTL_RESET   4'h0
// Bus answers
`define FC_RESP_OKAY   2'h0
`define FC_RESP_SLVERR 2'h2
// Operation numbers written to the command register
`define FC_OP_WRITE      5'h00
`define FC_OP_READ       5'h01
`define FC_OP_ARRAY      5'h02
`define FC_OP_IDENT      5'h03
`define FC_OP_STATUS     5'h04
`define FC_OP_CLEAR      5'h05
`define FC_OP_PROGRAM    5'h06
`define FC_OP_ERASE      5'h07
`define FC_OP_SUSPEND    5'h08
`define FC_OP_RESUME     5'h09
`define FC_OP_EXT_STATUS 5'h0A
`define FC_OP_BUF_READ   5'h0B
`define FC_OP_BUF_LOAD   5'h0C
`define FC_OP_SEQ_LOAD   5'h0D
`define FC_OP_BUF_FLASH  5'h0E
`define FC_OP_TWO_BYTE   5'h0F
`define FC_OP_LOCK       5'h10
`define FC_OP_UPLOAD     5'h11
`define FC_OP_ERASE_ALL  5'h12
`define FC_OP_RB_CONFIG  5'h13
`define FC_OP_SWAP       5'h14
`define FC_OP_ABORT      5'h15
`define FC_OP_SLEEP      5'h16
// Device command codes
`define FC_CMD_ARRAY     8'hFF
`define FC_CMD_IDENT     8'h90
`define FC_CMD_STATUS    8'h70
`define FC_CMD_CLEAR     8'h50
`define FC_CMD_PROGRAM   8'h40
`define FC_CMD_PROG_ALT  8'h10
`define FC_CMD_ERASE     8'h20
`define FC_CMD_CONFIRM   8'hD0
`define FC_CMD_SUSPEND   8'hB0
`define FC_CMD_EXT_STAT  8'h71
`define FC_CMD_SWAP      8'h72
`define FC_CMD_BUF_LOAD  8'h74
`define FC_CMD_BUF_READ  8'h75
`define FC_CMD_SEQ_LOAD  8'hE0
`define FC_CMD_BUF_FLASH 8'h0C
`define FC_CMD_TWO_BYTE  8'hFB
`define FC_CMD_LOCK      8'h77
`define FC_CMD_UPLOAD    8'h97
`define FC_CMD_ERASE_ALL 8'hA7
`define FC_CMD_RB_CONFIG 8'h96
`define FC_CMD_ABORT     8'h80
`define FC_CMD_SLEEP     8'hF0
`define FC_COUNT_HIGH    8'h00
// Strobe width: least time, rounded up to 25 MHz cycles
`define FC_CLOCK_MHZ     25
`define FC_STROBE_NS     120
`define FC_STROBE_CYC    ((`FC_STROBE_NS * `FC_CLOCK_MHZ + 999) / 1000)
`endif

// ==== hw/flash_host_pkg.sv ====
// Types shared by the flash host controller
package flash_host_pkg;
	// Kind of one flash bus cycle
	typedef enum logic [1:0] {CK_END, CK_WRITE, CK_READ} cyc_kind_t;
	// Where the cycle address comes from
	typedef enum logic [1:0] {AS_ZERO, AS_USER, AS_LOWBIT} addr_src_t;
	// Where the cycle data comes from
	typedef enum logic [1:0] {DS_CODE, DS_DATA, DS_DATA2} data_src_t;
	// Pin sequencer states
	typedef enum logic [2:0] {BS_IDLE, BS_FETCH, BS_SETUP, BS_STROBE, BS_HOLD,
		BS_RECOVER} bus_state_t;
	// One step of a command sequence
	typedef struct packed {
		cyc_kind_t   kind;
		addr_src_t   asrc;
		data_src_t   dsrc;
		logic [7:0]  code;
	} step_t;
	// Pins driven toward the flash device
	typedef struct packed {
		logic [20:0] address;
		logic [15:0] data_out;
		logic        data_oe;
		logic        chip_select_a_n;
		logic        chip_select_b_n;
		logic        output_enable_n;
		logic        write_strobe_n;
		logic        power_down_reset_n;
		logic        word_mode;
		logic        program_supply_on;
	} flash_pins_t;
endpackage : flash_host_pkg

// ==== verif/flash_device_model.sv ====
// Behavioural flash device answering the host controller's pins
`timescale 1ns/100ps
module flash_device_model
	import flash_host_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE  = 16'h00C3, // Arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h5E21, // Arbitrary value
	parameter int          BUSY_NS     = 2000      // Length of one machine operation
)(
	input  wire flash_pins_t pins,
	output logic [15:0]      dq,
	output logic             rb_low
);
	logic        busy = '0, susp = '0, es = '0, program_error = '0, program_supply_low = '0, rb_off = '0;
	logic [1:0]  mode = '0;     // Read mode: 0 array, 1 identifier, 2 status
	logic [2:0]  pend = '0;     // Second cycle awaited
	logic [1:0]  skip = '0;     // Data cycles still to swallow
	logic [7:0]  log_prev = '0, log_last = '0;
	logic [4:0]  last_block = '0;
	logic        ident_bad = '0, conflict = '0;
	logic [15:0] val, hold = '0;
	realtime     busy_end = 0;
	wire sel = pins.power_down_reset_n && !pins.chip_select_a_n && !pins.chip_select_b_n;
	wire drive = sel && !pins.output_enable_n && pins.write_strobe_n;
	wire hi = pins.word_mode ? pins.address[1] : pins.address[0];
	// Read value of the current mode
	always_comb begin
		case (mode)
			2'h1: val = hi ? DEVICE_CODE : MAKER_CODE;
			2'h2: val = {8'h00, !busy || susp, susp, es, program_error, program_supply_low, 3'h0};
			default: val = {~pins.address[7:0], pins.address[7:0] ^ 8'h5A};
		endcase
	end
	// Released lines show the inverse of the last value, upper byte floats in x8
	always @(val or drive) if (drive) hold = val;
	assign dq = drive ? {pins.word_mode ? val[15:8] : ~hold[15:8], val[7:0]} : ~hold;
	assign rb_low = busy && !susp && !rb_off;
	// Machine start, refused with low program supply
	task automatic start_op(input logic erase);
		if (!pins.program_supply_on) begin
			program_supply_low = 1'b1;
			es = es | erase;
			program_error = program_error | !erase;
		end else begin
			busy = 1'b1;
			busy_end = $realtime + BUSY_NS;
		end
		mode = 2'h2;
	endtask
	// Command decoder, latched on the strobe's rising edge
	always @(posedge pins.write_strobe_n) begin
		logic [7:0] d;
		d = pins.data_out[7:0];
		if (sel) begin
			log_prev = log_last;
			log_last = d;
			if (!pins.output_enable_n) conflict = 1'b1;
			if (skip != 0) begin
				skip = skip - 2'h1;
			end else if (pend != 0) begin
				case (pend)
					3'h1: start_op(1'b0);
					3'h2: begin
						if (d == 8'hD0) begin
							last_block = pins.address[20:16];
							start_op(1'b1);
						end else {es, program_error} = 2'h3;
					end
					3'h3: if (d == 8'hD0) mode = 2'h2;
					default: rb_off = (d == 8'h04);
				endcase
				pend = '0;
			end else begin
				case (d)
					8'hFF: mode = 2'h0;
					8'h90: mode = 2'h1;
					8'h70, 8'h71: mode = 2'h2;
					8'h50: {es, program_error, program_supply_low} = 3'h0;
					8'h40, 8'h10: pend = 3'h1;
					8'h20: pend = 3'h2;
					8'hA7, 8'h77, 8'h97: pend = 3'h3;
					8'h96: pend = 3'h4;
					8'hB0: if (busy) susp = 1'b1;
					8'hD0: susp = 1'b0;
					8'h80: busy = 1'b0;
					8'h74: skip = 2'h1;
					8'hE0, 8'h0C, 8'hFB: skip = 2'h2;
					default: ;
				endcase
			end
		end
	end
	// Identifier reads need the address bits above the selecting bit at zero
	always @(posedge drive) if (mode == 2'h1 && (pins.address[20:2] != 0 ||
		(!pins.word_mode && pins.address[1]))) ident_bad = 1'b1;
	always @(negedge pins.output_enable_n) #1 if (pins.data_oe) conflict = 1'b1;
	// Power-down clears the machine and all flags but ident_bad and conflict
	always @(negedge pins.power_down_reset_n) begin
		{busy, susp, es, program_error, program_supply_low, rb_off} = '0;
		pend = '0;
		skip = '0;
		mode = '0;
	end
	always #20 if (busy && $realtime >= busy_end) busy = 1'b0;
endmodule : flash_device_model

// ==== verif/flash_command_interface_tb.sv ====
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
module flash_command_interface_tb
	import flash_host_pkg::*;
;
	typedef struct packed {logic [4:0] op; logic [7:0] prev; logic [7:0] last; logic two;} row_t;
	logic        clock = '0, reset_n = '0;
	logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = '0;
	logic        awready, wready, bvalid, arready, rvalid, rb_low;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, st, rd;
	logic [15:0] data_in;
	flash_pins_t pins;
	int          err_count = 0, n_compared = 0;
	// Operation, expected earlier and last latched byte, earlier byte checked
	row_t rows [21] = '{
		'{5'h05, 8'h00, 8'h50, 1'b0}, '{5'h07, 8'h20, 8'hD0, 1'b1}, '{5'h08, 8'h00, 8'hB0, 1'b0},
		'{5'h09, 8'h00, 8'hD0, 1'b0}, '{5'h14, 8'h00, 8'h72, 1'b0}, '{5'h15, 8'h00, 8'h80, 1'b0},
		'{5'h16, 8'h00, 8'hF0, 1'b0}, '{5'h11, 8'h97, 8'hD0, 1'b1}, '{5'h12, 8'hA7, 8'hD0, 1'b1},
		'{5'h13, 8'h96, 8'h01, 1'b1}, '{5'h10, 8'h77, 8'hD0, 1'b1}, '{5'h06, 8'h40, 8'h01, 1'b1},
		'{5'h0C, 8'h74, 8'h01, 1'b1}, '{5'h0B, 8'h00, 8'h75, 1'b0}, '{5'h0A, 8'h00, 8'h71, 1'b0},
		'{5'h0D, 8'h01, 8'h00, 1'b1}, '{5'h0E, 8'h01, 8'h00, 1'b1}, '{5'h0F, 8'h01, 8'h03, 1'b1},
		'{5'h04, 8'h00, 8'h70, 1'b0}, '{5'h02, 8'h00, 8'hFF, 1'b0}, '{5'h03, 8'h00, 8'h90, 1'b0}};
	always #20 clock = ~clock;
	flash_command_host DUT (.clock(clock), .reset_n(reset_n), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .pins(pins), .data_in(data_in), .ready_busy_n(!rb_low));
	flash_device_model dev (.pins(pins), .dq(data_in), .rb_low(rb_low));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Register write and read over the bus
	task automatic wr(input logic [2:0] idx, input logic [31:0] d, input logic [1:0] er);
		awaddr <= {3'h0, idx, 2'h0};
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge clock); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge clock); while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rdr(input logic [2:0] idx, output logic [31:0] d, input logic [1:0] er);
		araddr <= {3'h0, idx, 2'h0};
		arvalid <= 1'b1;
		do @(posedge clock); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clock); while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	// Start an operation and poll until done
	task automatic run(input logic [4:0] op);
		int n;
		n = 0;
		wr(3'h3, {27'h0, op}, 2'h0);
		do begin
			rdr(3'h4, st, 2'h0);
			n++;
		end while (!(st[1] && !st[0]) && n < 100);
		if (n >= 100) err_count++;
	endtask
	task automatic waitrdy();
		int n;
		n = 0;
		do begin
			rdr(3'h4, st, 2'h0);
			n++;
		end while (!st[2] && n < 200);
		chk(st & 32'h4, 32'h4);
	endtask
	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#400000;
		err_count++;
		summarize();
	end
	// Reset, register map, table of operations, then the awkward cases
	initial begin
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		rdr(3'h0, rd, 2'h0);
		chk(rd, 32'h0);
		chk({29'h0, pins.chip_select_a_n, pins.power_down_reset_n, pins.data_oe}, 32'h4);
		rdr(3'h6, rd, 2'h2);
		chk(rd, 32'h0);
		wr(3'h7, 32'h1, 2'h2);
		wr(3'h0, 32'h5, 2'h0);
		wr(3'h1, 32'h000A1234, 2'h0);
		wr(3'h2, 32'h00030201, 2'h0);
		for (int i = 0; i < 21; i++) begin
			run(rows[i].op);
			chk({24'h0, dev.log_last}, {24'h0, rows[i].last});
			if (rows[i].two) chk({24'h0, dev.log_prev}, {24'h0, rows[i].prev});
		end
		rdr(3'h5, rd, 2'h0);
		chk(rd & 32'h00FF00FF, {8'h0, dev.DEVICE_CODE[7:0], 8'h0, dev.MAKER_CODE[7:0]});
		run(5'h02);
		rdr(3'h5, rd, 2'h0);
		chk(rd & 32'hFF, 32'h6E);
		chk(st & 32'h1F000000, 32'h0A000000);
		chk({27'h0, dev.last_block}, 32'hA);
		wr(3'h0, 32'h7, 2'h0);
		run(5'h03);
		rdr(3'h5, rd, 2'h0);
		chk(rd, {dev.DEVICE_CODE, dev.MAKER_CODE});
		wr(3'h0, 32'h1, 2'h0);
		// Second command lands while the first sequence still runs
		wr(3'h3, 32'h5, 2'h0);
		wr(3'h3, 32'h5, 2'h2);
		repeat (10) @(posedge clock);
		run(5'h07);
		run(5'h04);
		chk(st & 32'hFFF8, 32'hA858);
		run(5'h05);
		run(5'h04);
		chk(st & 32'hFF00, 32'h8000);
		wr(3'h0, 32'h5, 2'h0);
		wr(3'h2, 32'h20, 2'h0);
		run(5'h00);
		wr(3'h2, 32'h55, 2'h0);
		run(5'h00);
		run(5'h04);
		chk(st & 32'hFFF8, 32'hB0B8);
		run(5'h05);
		wr(3'h2, 32'h00030201, 2'h0);
		run(5'h07);
		rdr(3'h4, st, 2'h0);
		chk(st & 32'h4, 32'h0);
		waitrdy();
		run(5'h07);
		wr(3'h0, 32'h4, 2'h0);
		rdr(3'h4, st, 2'h0);
		chk(st & 32'hFF04, 32'h4);
		wr(3'h0, 32'hD, 2'h0);
		run(5'h04);
		chk(st & 32'hFF00, 32'h8000);
		run(5'h06);
		chk({24'h0, dev.log_prev}, 32'h10);
		chk({30'h0, dev.conflict, dev.ident_bad}, 32'h0);
		summarize();
	end
endmodule : flash_command_interface_tb
